// [csf_flag_reg.sv]
`timescale 1ns/1ps

module csf_flag_reg (
  input wire logic mclk, // CPU clock.
  input wire logic resetn, // Core reset, active low.
  input wire logic wr_en, // Instruction writes the state word.
  input wire logic [csf_pkg::WR_W-1:0] wr_data, // Written value, reserved bit on top.
  input wire csf_pkg::csf_alu_t alu_in, // ALU result and flag mask.
  input wire csf_pkg::csf_irq_t irq_in, // Maskable interrupt request.
  input wire logic hw_ack, // Hardware interrupt acknowledged.
  input wire logic sw_trap_en, // Software interrupt instruction executed.
  input wire logic [5:0] sw_trap_num, // Software interrupt number.
  output logic [csf_pkg::WORD_W-1:0] cpu_state_word, // Current state word.
  output logic rsvd_rd, // Reserved bit read value.
  output logic bank_sel, // Register bank select.
  output logic task_stack_sel, // High selects the task stack pointer.
  output logic [csf_pkg::IPL_W-1:0] cpu_priority_level, // Current level.
  output logic irq_accept // Request accepted, registered.
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [csf_pkg::WORD_W-1:0] word_q;
  logic [csf_pkg::WORD_W-1:0] word_d;
  logic rsvd_q;
  logic rsvd_d;
  logic accept_q;
  logic accept_d;
  logic zero_w;
  logic sign_w;
  logic trap_low_w;
  logic eligible_w;

  // ***************************************************************
  // Result decode
  // ***************************************************************

  // Zero and sign follow the operand size of the operation.
  // A byte operation looks only at the low result byte, so stale upper bits cannot leak in.
  always_comb
  begin
    if (alu_in.word_op)
    begin
      zero_w = (alu_in.result == csf_pkg::RESULT_ZERO); // [RULE3]
      sign_w = alu_in.result[csf_pkg::POS_WORD_MSB]; // [RULE4]
    end
    else
    begin
      zero_w = (alu_in.result[7:0] == csf_pkg::BYTE_ZERO); // [RULE3]
      sign_w = alu_in.result[csf_pkg::POS_BYTE_MSB]; // [RULE4]
    end
    trap_low_w = sw_trap_en && (sw_trap_num <= csf_pkg::TRAP_LOW_MAX); // [RULE10]
  end

  // ***************************************************************
  // Interrupt acceptance
  // ***************************************************************

  // The gate compares the request against the live mask and level.
  csf_irq_gate i_csf_irq_gate (
    .mask_gate(word_q[csf_pkg::POS_MASK]),
    .cpu_priority_level(word_q[csf_pkg::POS_IPL_HI:csf_pkg::POS_IPL_LO]),
    .irq_in(irq_in),
    .eligible(eligible_w)
  );

  // ***************************************************************
  // State word next value
  // ***************************************************************

  // A write replaces the word, otherwise only masked ALU flags move.
  // Acknowledge clears the gate and stack bits last, so it wins.
  always_comb
  begin
    word_d = word_q; // [RULE15]
    rsvd_d = 1'b0; // [RULE13]
    accept_d = eligible_w; // [RULE7] [RULE12]
    if (wr_en)
    begin
      word_d = wr_data[csf_pkg::WORD_W-1:0]; // [RULE14]
    end
    else
    begin
      if (alu_in.upd_c)
      begin
        word_d[csf_pkg::POS_CARRY] = alu_in.carry; // [RULE1]
      end
      if (alu_in.upd_z)
      begin
        word_d[csf_pkg::POS_ZERO] = zero_w; // [RULE3]
      end
      if (alu_in.upd_s)
      begin
        word_d[csf_pkg::POS_SIGN] = sign_w; // [RULE4]
      end
      if (alu_in.upd_o)
      begin
        word_d[csf_pkg::POS_OVF] = alu_in.ovf; // [RULE6]
      end
    end
    if (hw_ack || sw_trap_en)
    begin
      word_d[csf_pkg::POS_MASK] = 1'b0; // [RULE8]
    end
    if (hw_ack || trap_low_w)
    begin
      word_d[csf_pkg::POS_STACK] = 1'b0; // [RULE10]
    end
  end

  // Registers of the state word and the accept flag.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_q <= csf_pkg::WORD_RST;
      rsvd_q <= 1'b0;
      accept_q <= 1'b0;
    end
    else
    begin
      word_q <= word_d;
      rsvd_q <= rsvd_d;
      accept_q <= accept_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************

  // All outputs are taken straight from the registers.
  // The selects are slices of the word register, so they never glitch.
  assign cpu_state_word = word_q; // [RULE14]
  assign rsvd_rd = rsvd_q; // [RULE13]
  assign bank_sel = word_q[csf_pkg::POS_BANK]; // [RULE5]
  assign task_stack_sel = word_q[csf_pkg::POS_STACK]; // [RULE9]
  assign cpu_priority_level = word_q[csf_pkg::POS_IPL_HI:csf_pkg::POS_IPL_LO]; // [RULE11]
  assign irq_accept = accept_q;

  // ***************************************************************
  // Assertions
  // ***************************************************************

  // All checks run on the CPU clock and rest while the core is in reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Result flags follow the ALU when their update bit is set.
  a_carry_capture: assert property (alu_in.upd_c && !wr_en |=> word_q[0] == $past(alu_in.carry)) // [RULE1]
    else $error("Carry flag did not capture the ALU carry.");
  a_zero_result: assert property (alu_in.upd_z && !wr_en |=> word_q[2] == $past(zero_w)) // [RULE3]
    else $error("Zero flag does not match the result.");
  a_sign_result: assert property (alu_in.upd_s && !wr_en |=> word_q[3] == $past(sign_w)) // [RULE4]
    else $error("Sign flag does not match the result.");
  a_ovf_result: assert property (alu_in.upd_o && !wr_en |=> word_q[5] == $past(alu_in.ovf)) // [RULE6]
    else $error("Overflow flag does not match the operation.");

  // Unaffected flags hold, so a stray update cannot corrupt the word.
  a_keep_carry: assert property (!wr_en && !alu_in.upd_c |=> $stable(word_q[0])) // [RULE15]
    else $error("Carry flag changed without cause.");
  a_keep_zero: assert property (!wr_en && !alu_in.upd_z |=> $stable(word_q[csf_pkg::POS_ZERO])) // [RULE15]
    else $error("Zero flag changed without cause.");
  a_keep_sign: assert property (!wr_en && !alu_in.upd_s |=> $stable(word_q[csf_pkg::POS_SIGN])) // [RULE15]
    else $error("Sign flag changed without cause.");
  a_keep_ovf: assert property (!wr_en && !alu_in.upd_o |=> $stable(word_q[csf_pkg::POS_OVF])) // [RULE15]
    else $error("Overflow flag changed without cause.");
  a_keep_trace: assert property (!wr_en |=> $stable(word_q[csf_pkg::POS_TRACE])) // [RULE15]
    else $error("Trace bit changed without a write.");
  a_keep_mask: assert property (!wr_en && !hw_ack && !sw_trap_en |=> $stable(word_q[csf_pkg::POS_MASK])) // [RULE15]
    else $error("Mask gate changed without cause.");

  // An instruction write lands in the word, save what an acknowledge clears.
  a_word_write: assert property (wr_en && !hw_ack && !sw_trap_en // [RULE14]
    |=> cpu_state_word == $past(wr_data[csf_pkg::WORD_W-1:0]))
    else $error("Written word did not land.");
  a_bank_write: assert property (wr_en |=> bank_sel == $past(wr_data[csf_pkg::POS_BANK])) // [RULE5]
    else $error("Bank select does not follow the write.");
  a_bank_route: assert property (!wr_en |=> $stable(bank_sel) && bank_sel == word_q[4]) // [RULE5]
    else $error("Bank select moved without a write.");
  a_stack_write: assert property (wr_en && !hw_ack && !trap_low_w // [RULE9]
    |=> task_stack_sel == $past(wr_data[csf_pkg::POS_STACK]))
    else $error("Stack select does not follow the write.");
  a_stack_hold: assert property (!wr_en && !hw_ack && !trap_low_w |=> $stable(task_stack_sel)) // [RULE9]
    else $error("Stack select moved without cause.");
  a_prio_write: assert property (wr_en // [RULE11]
    |=> cpu_priority_level == $past(wr_data[csf_pkg::POS_IPL_HI:csf_pkg::POS_IPL_LO]))
    else $error("Priority level does not follow the write.");
  a_prio_hold: assert property (!wr_en |=> $stable(cpu_priority_level)) // [RULE11]
    else $error("Priority level moved without a write.");
  a_rsvd_zero: assert property (wr_en ##1 1'b1 |-> !rsvd_rd) // [RULE13]
    else $error("Reserved bit read back nonzero.");

  // The interrupt gate accepts exactly the eligible requests.
  a_mask_refuse: assert property (!word_q[6] |=> !irq_accept) // [RULE7]
    else $error("Interrupt accepted while masked.");
  a_prio_strict: assert property (irq_accept |-> $past(irq_in.prio) > $past(cpu_priority_level)) // [RULE12]
    else $error("Accepted priority not above current level.");
  a_prio_accept: assert property (irq_in.req && word_q[csf_pkg::POS_MASK] // [RULE12]
    && (irq_in.prio > cpu_priority_level) |=> irq_accept)
    else $error("Eligible request was not accepted.");

  // Hardware acknowledge clears the gate and the stack bit, a trap the gate and, for low trap numbers, the stack bit.
  a_ack_clears_mask: assert property (hw_ack || sw_trap_en |=> !word_q[6]) // [RULE8]
    else $error("Mask gate not cleared on acknowledge.");
  a_ack_clears_stack: assert property (hw_ack || trap_low_w |=> !task_stack_sel) // [RULE10]
    else $error("Stack bit not cleared on acknowledge.");
  a_high_trap_keeps: assert property (sw_trap_en && sw_trap_num > 6'h1F && !wr_en && !hw_ack // [RULE10]
    |=> $stable(word_q[7]))
    else $error("High trap number changed the stack bit.");

  // Main scenarios that the bench should reach.
  c_accept: cover property (irq_in.req ##1 irq_accept);
  c_hw_ack: cover property (word_q[6] && hw_ack ##1 !word_q[6]);
  c_zero_set: cover property (alu_in.upd_z && zero_w ##1 word_q[2]);
  c_low_trap: cover property (task_stack_sel && trap_low_w ##1 !task_stack_sel);
  c_mask_block: cover property (irq_in.req && !word_q[csf_pkg::POS_MASK] ##1 !irq_accept);

endmodule : csf_flag_reg

// [csf_pkg.sv]
// Operation
// [RULE1] Carry flag keeps ALU carry, borrow, shift-out.
// [RULE2] Software always writes the trace bit as zero.
// [RULE3] Zero flag set on zero result, else cleared.
// [RULE4] Sign flag set on negative result, else cleared.
// [RULE5] Bank bit selects register bank 0 or 1.
// [RULE6] Overflow flag follows overflow of each operation.
// [RULE7] Mask gate zero refuses all maskable interrupts.
// [RULE8] Any interrupt acknowledge clears the mask gate.
// [RULE9] Stack bit picks handler or task stack.
// [RULE10] Hardware acknowledge or low trap clears stack bit.
// [RULE11] Priority level field is three bits, 0 to 7.
// [RULE12] Accept only priority strictly above current level.
// [RULE13] Reserved bit written zero, read value is meaningless.
// [RULE14] State word is eleven bits of current state.
// [RULE15] Unaffected flags keep their previous values.

package csf_pkg;

  // ***************************************************************
  // State word layout
  // ***************************************************************
  localparam int WORD_W = 11;
  localparam int WR_W = 12;
  localparam int POS_CARRY = 0;
  localparam int POS_TRACE = 1;
  localparam int POS_ZERO = 2;
  localparam int POS_SIGN = 3;
  localparam int POS_BANK = 4;
  localparam int POS_OVF = 5;
  localparam int POS_MASK = 6;
  localparam int POS_STACK = 7;
  localparam int POS_IPL_LO = 8;
  localparam int POS_IPL_HI = 10;
  localparam int POS_RSVD = 11;
  localparam int IPL_W = 3;
  localparam logic [WORD_W-1:0] WORD_RST = 11'h000;

  // ***************************************************************
  // Result and trap constants
  // ***************************************************************
  localparam int POS_BYTE_MSB = 7;
  localparam int POS_WORD_MSB = 15;
  localparam logic [5:0] TRAP_LOW_MAX = 6'h1F;
  localparam logic [15:0] RESULT_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Result of one ALU operation with its flag update mask.
  typedef struct packed {
    logic upd_c;
    logic upd_z;
    logic upd_s;
    logic upd_o;
    logic carry;
    logic ovf;
    logic word_op;
    logic [15:0] result;
  } csf_alu_t;

  // One pending maskable interrupt request.
  typedef struct packed {
    logic req;
    logic [IPL_W-1:0] prio;
  } csf_irq_t;

endpackage : csf_pkg

// [csf_irq_gate.sv]
`timescale 1ns/1ps

module csf_irq_gate (
  input wire logic mask_gate, // Maskable interrupt enable bit.
  input wire logic [csf_pkg::IPL_W-1:0] cpu_priority_level, // Current level.
  input wire csf_pkg::csf_irq_t irq_in, // Pending request.
  output logic eligible // Request may be accepted.
);

  // A request passes only when enabled and strictly above the level.
  always_comb
  begin
    eligible = irq_in.req && mask_gate && (irq_in.prio > cpu_priority_level); // [RULE7] [RULE12]
  end

endmodule : csf_irq_gate

// [csf_flag_reg_tb.sv]
`timescale 1ns/1ps

// ***************************************************************
// State word bench
// ***************************************************************
module csf_flag_reg_tb;
  localparam logic [22:0] NO_ALU = 23'h00_0000;
  logic mclk, resetn, wr_en, hw_ack, sw_trap_en, rsvd_rd, bank_sel, task_stack_sel, irq_accept;
  logic [11:0] wr_data;
  logic [5:0] sw_trap_num;
  logic [10:0] cpu_state_word;
  logic [2:0] cpu_priority_level;
  csf_pkg::csf_alu_t alu_in;
  csf_pkg::csf_irq_t irq_in;
  int fail_count, checked, cycles;
  logic [1:0] ack_evt [3] = '{2'h1, 2'h2, 2'h2};
  logic [5:0] ack_num [3] = '{6'h00, 6'h1F, 6'h20};
  logic [10:0] ack_exp [3] = '{11'h405, 11'h405, 11'h485};

  csf_flag_reg i_csf_flag_reg (.mclk(mclk), .resetn(resetn), .wr_en(wr_en), .wr_data(wr_data),
    .alu_in(alu_in), .irq_in(irq_in), .hw_ack(hw_ack), .sw_trap_en(sw_trap_en),
    .sw_trap_num(sw_trap_num), .cpu_state_word(cpu_state_word), .rsvd_rd(rsvd_rd),
    .bank_sel(bank_sel), .task_stack_sel(task_stack_sel),
    .cpu_priority_level(cpu_priority_level), .irq_accept(irq_accept));

  // Clock of 50 ns period.
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Drives one request at a rising edge, lets the next edge take it, then settles.
  task automatic apply(input logic we, input logic [11:0] wd, input logic [22:0] alu, input logic [3:0] irq,
                       input logic [1:0] evt, input logic [5:0] num);
    @(posedge mclk);
    wr_en <= we;
    wr_data <= wd;
    alu_in <= alu;
    irq_in <= irq;
    hw_ack <= evt[0];
    sw_trap_en <= evt[1];
    sw_trap_num <= num;
    @(posedge mclk);
    wr_en <= 1'h0;
    alu_in <= NO_ALU;
    irq_in <= 4'h0;
    hw_ack <= 1'h0;
    sw_trap_en <= 1'h0;
    #1;
  endtask : apply

  // Writes the state word by instruction.
  task automatic wr(input logic [11:0] wd);
    apply(1'h1, wd, NO_ALU, 4'h0, 2'h0, 6'h00);
  endtask : wr

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // Main sequence of tests.
  initial
  begin
    int p;
    {resetn, wr_en, hw_ack, sw_trap_en, wr_data, sw_trap_num} = '0;
    alu_in = NO_ALU;
    irq_in = 4'h0;
    repeat (3) @(posedge mclk);
    chk(cpu_state_word, 16'h0000);
    chk(rsvd_rd, 16'h0000);
    resetn <= 1'h1;
    $display("test reset done");
    wr(12'h7FD);
    chk(cpu_state_word, 16'h07FD);
    chk(rsvd_rd, 16'h0000);
    chk(bank_sel, 16'h0001);
    chk(task_stack_sel, 16'h0001);
    chk(cpu_priority_level, 16'h0007);
    wr(12'h000);
    chk(bank_sel, 16'h0000);
    chk(task_stack_sel, 16'h0000);
    chk(cpu_priority_level, 16'h0000);
    $display("test write done");
    apply(1'h0, 12'h000, {4'hF, 1'h1, 1'h1, 1'h0, 16'h0100}, 4'h0, 2'h0, 6'h00);
    chk(cpu_state_word, 16'h0025);
    apply(1'h0, 12'h000, {4'hF, 1'h0, 1'h0, 1'h1, 16'h8000}, 4'h0, 2'h0, 6'h00);
    chk(cpu_state_word, 16'h0008);
    apply(1'h0, 12'h000, {4'h4, 1'h1, 1'h1, 1'h0, 16'h0000}, 4'h0, 2'h0, 6'h00);
    chk(cpu_state_word, 16'h000C);
    $display("test alu done");
    wr(12'h240);
    for (p = 0; p < 8; p++)
    begin
      apply(1'h0, 12'h000, NO_ALU, {1'h1, p[2:0]}, 2'h0, 6'h00);
      chk(irq_accept, (p > 2) ? 16'h0001 : 16'h0000);
    end
    wr(12'h200);
    apply(1'h0, 12'h000, NO_ALU, 4'hF, 2'h0, 6'h00);
    chk(irq_accept, 16'h0000);
    $display("test interrupt done");
    for (p = 0; p < 3; p++)
    begin
      wr(12'h4C5);
      apply(1'h0, 12'h000, NO_ALU, 4'h0, ack_evt[p], ack_num[p]);
      chk(cpu_state_word, ack_exp[p]);
    end
    apply(1'h1, 12'h0C0, NO_ALU, 4'h0, 2'h1, 6'h00);
    chk(cpu_state_word, 16'h0000);
    $display("test acknowledge done");
    wr(12'h7FD);
    @(posedge mclk);
    resetn <= 1'h0;
    #1;
    chk(cpu_state_word, 16'h0000);
    chk(bank_sel, 16'h0000);
    @(posedge mclk);
    resetn <= 1'h1;
    wr(12'h305);
    chk(cpu_state_word, 16'h0305);
    chk(cpu_priority_level, 16'h0003);
    $display("test mid reset done");
    complete_run();
  end
endmodule : csf_flag_reg_tb
